// ===== rtl/ach_host_ctl.sv
// Host control of an async serial controller, one bit per bus word.
// Assumes an APB master on pclk and modem pins from outside.
//
// Contract
// - Reset command: interrupts off, load flags set
// - Final register bit clears its load flag
// - Internal clock is input clock over three
// - Interval counts 64 microsecond steps
// - Timer interrupt each interval when enabled
// - Load order control, interval, rx, tx rate
// - Tx rate with rx flag loads both
// - Request-to-send bit turns transmitter on
// - No shifting until clear-to-send active
// - Transmitter stays on until last character sent
// - Host polls empty; char write clears it
// - Set load flag then write to reload
// - Writes go to register while flag set
// - Timer reloads at zero, flags elapsed/overrun
// - Low interrupt on any enabled condition
// - Enable write clears pending condition (a transmit enable write leaves tx_empty set)
// - Five-bit code selects one bit
`timescale 1ns/1ps
`default_nettype none
module ach_host_ctl
  import ach_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem pins, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic rts_n,
  output logic irq_n,
  // Serial output
  output logic tx_out,
  // Characters from the receiver
  input wire logic [7:0] rx_char,
  input wire logic rx_strobe
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic pready;         // Access phase answer
    logic pslverr;        // Unmapped address
    logic rd_bit;         // Read bit for this access
    logic ld_ctrl, ld_intv, ld_rxr, ld_txr; // Load flags, in load order
    logic [7:0] ctrl;     // Control register
    logic [7:0] intv;     // Interval register
    logic [10:0] rxr;     // rx_rate_register
    logic [11:0] txr;     // tx_rate_register
    logic [7:0] tx_buf;   // Transmit buffer
    logic tx_empty;       // tx_buffer_empty
    logic [7:0] rx_buf;   // Receive buffer
    logic rx_loaded;      // rx_buffer_loaded
    logic en_rx, en_tx, en_tim, en_dsc; // Interrupt enables
    logic rts_on;         // request_to_send_on
    logic rts_act;        // Transmitter active
    logic rts_n, irq_n;   // Pin copies
    logic [1:0] div;      // Divide by three
    logic tick;           // Internal clock enable
    logic [5:0] step;     // 64-clock step counter
    logic [7:0] tcnt;     // Interval down counter
    logic elapsed, overrun; // Timer elapsed and overrun flags
    logic init;           // Soft reset to serializer
    logic [2:0] cts_s, dsr_s; // Pin synchronisers
    logic cts_q, dsr_q;   // Settled pin levels
    logic dsc;            // Modem status changed
  } ach_top_s;

  ach_top_s q;
  ach_top_s n;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic setup;            // Setup phase of a transfer
  logic acc;              // Access phase being completed
  logic wr_ok;            // Write takes effect this edge
  logic [4:0] code;       // bit_select_code
  logic v;                // Written bit value
  logic any_ld;           // Some load flag set

  assign code = paddr[SEL_HI:SEL_LO];
  assign v = pwdata[0];
  assign setup = psel && !penable;
  assign acc = psel && penable && q.pready;
  assign wr_ok = acc && pwrite && !q.pslverr;
  assign any_ld = q.ld_ctrl || q.ld_intv || q.ld_rxr || q.ld_txr;

  ach_tx_if txl ();

  ach_tx_serializer u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .tx(txl.ser)
  );

  assign txl.chr = q.tx_buf;
  assign txl.full = !q.tx_empty;
  assign txl.go = q.rts_act && !q.cts_q;
  assign txl.init = q.init;
  assign txl.tick = q.tick;
  assign txl.rate = q.txr;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.init = 1'b0;
    n.pready = setup;
    n.pslverr = setup && (paddr >= ADDR_LIMIT);

    // Read bit is picked in setup, held through access
    n.rd_bit = 1'b0;
    if (setup && !(paddr >= ADDR_LIMIT)) begin
      if (code <= CHAR_LAST) begin
        n.rd_bit = q.rx_buf[code[2:0]];
      end else begin
        case (code)
          BIT_LD_TXR: n.rd_bit = q.ld_txr;
          BIT_LD_RXR: n.rd_bit = q.ld_rxr;
          BIT_LD_INTV: n.rd_bit = q.ld_intv;
          BIT_LD_CTRL: n.rd_bit = q.ld_ctrl;
          BIT_RTS_ON: n.rd_bit = q.rts_on;
          RD_RX_LOADED: n.rd_bit = q.rx_loaded;
          RD_TX_EMPTY: n.rd_bit = q.tx_empty;
          RD_ELAPSED: n.rd_bit = q.elapsed;
          RD_OVERRUN: n.rd_bit = q.overrun;
          RD_CTS: n.rd_bit = !q.cts_q;
          RD_DSR: n.rd_bit = !q.dsr_q;
          RD_DSC: n.rd_bit = q.dsc;
          RD_RTS_ACT: n.rd_bit = q.rts_act;
          RD_INT: n.rd_bit = !q.irq_n;
          default: n.rd_bit = 1'b0;
        endcase
      end
    end

    n.tick = (q.div == DIV_LAST);
    n.div = n.tick ? 2'h0 : q.div + 2'h1;

    if (q.tick) begin
      n.step = q.step + 6'h01;
      if (q.step == STEP_LAST) begin
        if (q.tcnt <= TCNT_ONE) begin
          n.tcnt = q.intv;
          if (q.elapsed) begin
            n.overrun = 1'b1;
          end else begin
            n.elapsed = 1'b1;
          end
        end else begin
          n.tcnt = q.tcnt - 8'h01;
        end
      end
    end

    // Bus write; hardware sets below win over its clears
    if (wr_ok) begin
      if (code == BIT_RESET) begin
        if (v) begin
          {n.ld_ctrl, n.ld_intv, n.ld_rxr, n.ld_txr} = 4'hF;
          {n.en_rx, n.en_tx, n.en_tim, n.en_dsc} = 4'h0;
          {n.elapsed, n.overrun, n.rx_loaded, n.dsc} = 4'h0;
          n.tx_empty = 1'b1;
          n.rts_on = 1'b0;
          n.step = '0;
          n.init = 1'b1;
        end
      end else if (any_ld && code <= TXR_LAST) begin
        // steer to register; order by priority
        if (q.ld_ctrl) begin
          if (code <= CTRL_LAST) begin
            n.ctrl[code[2:0]] = v;
          end
          if (code == CTRL_LAST) begin
            n.ld_ctrl = 1'b0;
          end
        end else if (q.ld_intv) begin
          if (code <= INTV_LAST) begin
            n.intv[code[2:0]] = v;
          end
          if (code == INTV_LAST) begin
            n.ld_intv = 1'b0;
            n.tcnt = n.intv;
            n.step = '0;
          end
        end else begin
          // Both rate registers take the bit while both flags set
          if (q.ld_rxr && code <= RXR_LAST) begin
            n.rxr[code[3:0]] = v;
          end
          if (q.ld_txr) begin
            n.txr[code[3:0]] = v;
          end
          // rx flag ends at bit 10, tx flag at bit 11
          if (code == RXR_LAST) begin
            n.ld_rxr = 1'b0;
          end
          if (code == TXR_LAST) begin
            n.ld_txr = 1'b0;
          end
        end
      end else begin
        case (code)
          BIT_LD_TXR: n.ld_txr = v;
          BIT_LD_RXR: n.ld_rxr = v;
          BIT_LD_INTV: n.ld_intv = v;
          BIT_LD_CTRL: n.ld_ctrl = v;
          BIT_RTS_ON: n.rts_on = v;
          BIT_EN_RX: begin
            n.en_rx = v;
            n.rx_loaded = 1'b0;
          end
          BIT_EN_TX: n.en_tx = v;
          BIT_EN_TIM: begin
            n.en_tim = v;
            // A fresh timer event in this cycle beats the clear
            n.elapsed = n.elapsed && !q.elapsed;
          end
          BIT_EN_DSC: begin
            n.en_dsc = v;
            n.dsc = 1'b0;
          end
          default: begin
            if (code <= CHAR_LAST) begin
              n.tx_buf[code[2:0]] = v;
              if (code == CHAR_LAST) begin
                n.tx_empty = 1'b0;
              end
            end
          end
        endcase
      end
    end

    // Serializer took the character
    if (txl.taken) begin
      n.tx_empty = 1'b1;
    end

    if (rx_strobe) begin
      n.rx_buf = rx_char;
      n.rx_loaded = 1'b1;
    end

    // Pin level counts once second and third flops agree
    n.cts_s = {q.cts_s[1:0], cts_n};
    n.dsr_s = {q.dsr_s[1:0], dsr_n};
    if (q.cts_s[1] == q.cts_s[2]) begin
      n.cts_q = q.cts_s[2];
    end
    if (q.dsr_s[1] == q.dsr_s[2]) begin
      n.dsr_q = q.dsr_s[2];
    end
    if (n.cts_q != q.cts_q || n.dsr_q != q.dsr_q) begin
      n.dsc = 1'b1;
    end

    // stay active until the last character is out
    n.rts_act = n.rts_on ||
                (q.rts_act && (txl.busy || !n.tx_empty));
    n.rts_n = !n.rts_act;

    n.irq_n = !((n.dsc && n.en_dsc) || (n.rx_loaded && n.en_rx) ||
                (n.tx_empty && n.en_tx) ||
                (n.elapsed && n.en_tim));
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      {q.ld_ctrl, q.ld_intv, q.ld_rxr, q.ld_txr} <= 4'hF;
      {q.tx_empty, q.rts_n, q.irq_n} <= 3'h7;
      {q.cts_s, q.dsr_s} <= 6'h3F;
      {q.cts_q, q.dsr_q} <= 2'h3;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flops
  assign prdata = {{(DATA_W-1){1'b0}}, q.rd_bit};
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign rts_n = q.rts_n;
  assign irq_n = q.irq_n;
  assign tx_out = txl.dout;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_reset_cmd_flags: assert property (
    wr_ok && code == BIT_RESET && v |=>
      q.ld_ctrl && q.ld_intv && q.ld_rxr && q.ld_txr &&
      !q.en_rx && !q.en_tx && !q.en_tim && !q.en_dsc ##1 q.irq_n)
    else $error("reset command did not set flags");
  chk_final_bit_clear: assert property (
    wr_ok && q.ld_ctrl && code == CTRL_LAST |=>
      !q.ld_ctrl && q.ld_intv == $past(q.ld_intv))
    else $error("control load flag not cleared");
  chk_tick_third: assert property (
    q.tick |=> !q.tick ##1 !q.tick ##1 q.tick)
    else $error("internal clock not one in three");
  chk_dual_rate_load: assert property (
    wr_ok && !q.ld_ctrl && !q.ld_intv && q.ld_rxr && q.ld_txr &&
      code == RXR_LAST |=>
      !q.ld_rxr && q.ld_txr && q.rxr[PRE_BIT] == q.txr[PRE_BIT])
    else $error("rate bit not loaded into both");
  chk_rts_hold: assert property (
    !q.rts_n && (txl.busy || !q.tx_empty) &&
      !(wr_ok && code == BIT_RESET) |=> !q.rts_n)
    else $error("transmitter dropped with data pending");
  chk_char_clears_empty: assert property (
    wr_ok && !any_ld && code == CHAR_LAST && q.tx_empty |=>
      !q.tx_empty && q.tx_buf[7] == $past(v))
    else $error("character write left buffer empty");
  chk_steer_keeps_buf: assert property (
    wr_ok && any_ld && code <= CHAR_LAST |=>
      q.tx_buf == $past(q.tx_buf))
    else $error("load write reached transmit buffer");
  chk_timer_reload: assert property (
    q.tick && q.step == STEP_LAST && q.tcnt <= TCNT_ONE &&
      !q.elapsed && !wr_ok |=>
      q.elapsed && q.tcnt == $past(q.intv))
    else $error("timer did not reload and flag");
  chk_irq_level: assert property (
    q.irq_n == !((q.dsc && q.en_dsc) || (q.rx_loaded && q.en_rx) ||
                 (q.tx_empty && q.en_tx) ||
                 (q.elapsed && q.en_tim)))
    else $error("interrupt pin disagrees with sources");

endmodule // ach_host_ctl
`default_nettype wire

// ===== rtl/ach_pkg.sv
// Shared constants for the async comm controller host control block.
// Assumes a 100 MHz pclk and the 5-bit bit-select map held below.
package ach_pkg;

  // ----------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // First byte address past the 32 one-bit words
  localparam logic [ADDR_W-1:0] ADDR_LIMIT = 8'h80;
  // Bit select code sits in paddr[6:2]
  localparam int SEL_LO = 2;
  localparam int SEL_HI = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Internal clock is pclk divided by three
  localparam int INT_DIV = 3;
  localparam logic [1:0] DIV_LAST = 2'(INT_DIV - 1);
  // Interval step is 64 internal clocks (64 us at 1 MHz)
  localparam int STEP_CLKS = 64;
  localparam logic [5:0] STEP_LAST = 6'(STEP_CLKS - 1);
  localparam logic [7:0] TCNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Register widths and final bit codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CHAR_LAST = 5'h07;
  localparam logic [4:0] CTRL_LAST = 5'h07;
  localparam logic [4:0] INTV_LAST = 5'h07;
  localparam logic [4:0] RXR_LAST = 5'h0A;
  localparam logic [4:0] TXR_LAST = 5'h0B;
  localparam int RATE_W = 10;
  localparam int PRE_BIT = 10;
  localparam int CNT_W = 13;
  // Start, eight data bits, stop
  localparam logic [3:0] FRAME_LAST = 4'h9;

  // ----------------------------------------------------------------
  // Bit select codes, write side
  // ----------------------------------------------------------------
  localparam logic [4:0] BIT_LD_TXR = 5'h0B;
  localparam logic [4:0] BIT_LD_RXR = 5'h0C;
  localparam logic [4:0] BIT_LD_INTV = 5'h0D;
  localparam logic [4:0] BIT_LD_CTRL = 5'h0E;
  localparam logic [4:0] BIT_RTS_ON = 5'h10;
  localparam logic [4:0] BIT_EN_RX = 5'h12;
  localparam logic [4:0] BIT_EN_TX = 5'h13;
  localparam logic [4:0] BIT_EN_TIM = 5'h14;
  localparam logic [4:0] BIT_EN_DSC = 5'h15;
  localparam logic [4:0] BIT_RESET = 5'h1F;

  // ----------------------------------------------------------------
  // Bit select codes, read side
  // ----------------------------------------------------------------
  localparam logic [4:0] RD_RX_LOADED = 5'h15;
  localparam logic [4:0] RD_TX_EMPTY = 5'h16;
  localparam logic [4:0] RD_ELAPSED = 5'h17;
  localparam logic [4:0] RD_OVERRUN = 5'h18;
  localparam logic [4:0] RD_CTS = 5'h19;
  localparam logic [4:0] RD_DSR = 5'h1A;
  localparam logic [4:0] RD_DSC = 5'h1B;
  localparam logic [4:0] RD_RTS_ACT = 5'h1C;
  localparam logic [4:0] RD_INT = 5'h1F;

endpackage

// ===== rtl/ach_tx_if.sv
// Link between the control block and its character serializer.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface ach_tx_if;
  logic [7:0] chr;     // Buffered character
  logic full;          // Buffer holds a character
  logic go;            // Transmitter on and clear to send
  logic init;          // Soft reset pulse
  logic tick;          // Internal clock enable
  logic [11:0] rate;   // Transmit rate register
  logic taken;         // Character moved into shifter
  logic busy;          // Frame in progress
  logic dout;          // Serial line level
  modport ctl (output chr, full, go, init, tick, rate,
               input taken, busy, dout);
  modport ser (input chr, full, go, init, tick, rate,
               output taken, busy, dout);
endinterface
`default_nettype wire

// ===== rtl/ach_tx_serializer.sv
// Character serializer: start bit, eight data bits LSB first, stop.
// Assumes tick pulses once per internal clock from the control block.
`timescale 1ns/1ps
`default_nettype none
module ach_tx_serializer
  import ach_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  ach_tx_if.ser tx
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic busy;              // Frame in progress
    logic taken;             // One-cycle take pulse
    logic dout;              // Line level
    logic half;              // Second half of a bit
    logic [3:0] bitn;        // Bits already sent
    logic [9:0] shr;         // Frame shifter
    logic [CNT_W-1:0] rcnt;  // Half-bit counter
  } ach_ser_s;

  ach_ser_s q;
  ach_ser_s n;
  logic [CNT_W-1:0] lim;     // Internal clocks per half bit

  // Half bit = optional prescale of eight times the rate count
  // rate divider
  assign lim = tx.rate[PRE_BIT] ? {tx.rate[RATE_W-1:0], 3'h0}
                                : {3'h0, tx.rate[RATE_W-1:0]};

  // Next state
  always_comb begin
    n = q;
    n.taken = 1'b0;
    if (tx.init) begin
      // Soft reset drops any frame at once
      n.busy = 1'b0;
      n.half = 1'b0;
      n.rcnt = '0;
    end else if (!q.busy) begin
      if (tx.full && tx.go) begin
        n.busy = 1'b1;
        n.taken = 1'b1;
        n.shr = {1'b1, tx.chr, 1'b0};
        n.bitn = '0;
        n.half = 1'b0;
        n.rcnt = '0;
      end
    end else if (tx.tick) begin
      // Two half bits make one bit
      if ((q.rcnt + 13'h0001) >= lim) begin
        n.rcnt = '0;
        n.half = !q.half;
        if (q.half) begin
          n.shr = {1'b1, q.shr[9:1]};
          n.bitn = q.bitn + 4'h1;
          if (q.bitn == FRAME_LAST) begin
            n.busy = 1'b0;
          end
        end
      end else begin
        n.rcnt = q.rcnt + 13'h0001;
      end
    end
    // Line idles high between frames
    n.dout = n.busy ? n.shr[0] : 1'b1;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.dout <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign tx.taken = q.taken;
  assign tx.busy = q.busy;
  assign tx.dout = q.dout;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_needs_clear: assert property (
    $rose(q.busy) |-> $past(tx.go) && !q.dout)
    else $error("frame started without clear to send");

endmodule // ach_tx_serializer
`default_nettype wire

// ===== verif/ach_line_model.sv
// Line side model: modem pins and a receiver for the serial output.
// Assumes a shared pclk and a fixed bit length counted in pclk cycles.
`timescale 1ns/1ps
`default_nettype none
module ach_line_model #(
  parameter int BIT_CLKS = 12
) (
  // Clock
  input wire logic pclk,
  // Bench control
  input wire logic cts_en,
  // Serial line and modem pins
  input wire logic tx_out,
  output logic cts_n,
  output logic dsr_n,
  // Captured characters
  output logic [7:0] got,
  output logic [3:0] n_frames
);
  // Data set ready stays off; clear to send follows the bench
  assign dsr_n = 1'b1;
  always @(posedge pclk) begin
    cts_n <= !cts_en;
  end
  // Mid-bit sampling; a frame counts only with a good stop bit
  initial begin
    got = 8'h00;
    n_frames = 4'h0;
    forever begin
      @(negedge tx_out);
      repeat (BIT_CLKS / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge pclk);
        got[i] = tx_out;
      end
      repeat (BIT_CLKS) @(posedge pclk);
      if (tx_out === 1'b1) begin
        n_frames = n_frames + 4'h1;
      end
    end
  end
endmodule // ach_line_model
`default_nettype wire

// ===== verif/async_comm_host_control_tb.sv
// Bench for the host control block: APB master, line model, checks.
// Assumes the package, design and line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module async_comm_host_control_tb
  import ach_pkg::*;
;
  // Rate 2 gives half bits of 2 ticks, so 12 pclk per bit
  localparam int RATE = 2;
  localparam int BIT_CLKS = 2 * RATE * INT_DIV;
  logic pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic pready, pslverr, cts_n, dsr_n, rts_n, irq_n, tx_out;
  logic [7:0] rx_char, got;
  logic rx_strobe, cts_en;
  logic [3:0] n_frames;
  int n_errors, tests_run;

  ach_host_ctl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n),
    .dsr_n(dsr_n), .rts_n(rts_n), .irq_n(irq_n), .tx_out(tx_out),
    .rx_char(rx_char), .rx_strobe(rx_strobe));
  ach_line_model #(.BIT_CLKS(BIT_CLKS)) line_u (.pclk(pclk),
    .cts_en(cts_en), .tx_out(tx_out), .cts_n(cts_n), .dsr_n(dsr_n),
    .got(got), .n_frames(n_frames));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] x);
    tests_run++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one bit per access, code in the word address
  task automatic apb(input logic w, input logic [7:0] a, input logic d,
                     output logic q, output logic e);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {31'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata[0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) n_errors++;
  endtask
  task automatic wr(input logic [4:0] c, input logic d);
    logic q;
    logic e;
    apb(1'b1, {1'b0, c, 2'b00}, d, q, e);
  endtask
  task automatic rc(input logic [4:0] c, input logic x);
    logic q;
    logic e;
    apb(1'b0, {1'b0, c, 2'b00}, 1'b0, q, e);
    chk($sformatf("bit%0d", c), {7'h0, q}, {7'h0, x});
  endtask
  // Multi-bit values go out bit 0 first, one access each
  task automatic ld(input logic [11:0] v, input int n);
    for (int i = 0; i < n; i++) wr(5'(i), v[i]);
  endtask

  // state after reset, and a refused access
  task automatic t_reset();
    logic q;
    logic e;
    chk("rts_n", {7'h0, rts_n}, 8'h01);
    chk("irq_n", {7'h0, irq_n}, 8'h01);
    chk("tx_out", {7'h0, tx_out}, 8'h01);
    for (int i = 11; i < 15; i++) rc(5'(i), 1'b1);
    rc(RD_TX_EMPTY, 1'b1);
    apb(1'b0, ADDR_LIMIT, 1'b0, q, e);
    chk("pslverr", {7'h0, e}, 8'h01);
    chk("unmapped", {7'h0, q}, 8'h00);
  endtask
  // two steps of 64 ticks each, then overrun
  task automatic t_timer();
    int t;
    ld(12'h0A2, 8);
    rc(BIT_LD_CTRL, 1'b0);
    rc(BIT_LD_INTV, 1'b1);
    ld(12'h002, 8);
    rc(BIT_LD_INTV, 1'b0);
    wait_clk(320);
    rc(RD_ELAPSED, 1'b0);
    wait_clk(70);
    rc(RD_ELAPSED, 1'b1);
    wait_clk(380);
    rc(RD_OVERRUN, 1'b1);
    chk("irq_off", {7'h0, irq_n}, 8'h01);
    wr(BIT_EN_TIM, 1'b1);
    wait_clk(2);
    chk("irq_clr", {7'h0, irq_n}, 8'h01);
    t = 0;
    while (irq_n !== 1'b0 && t < 500) begin
      wait_clk(1);
      t++;
    end
    chk("irq_on", {7'h0, irq_n}, 8'h00);
    chk("gap", 8'(t > 340 && t < 400), 8'h01);
    wr(BIT_EN_TIM, 1'b0);
    wait_clk(2);
    chk("irq_dis", {7'h0, irq_n}, 8'h01);
    rc(RD_ELAPSED, 1'b0);
  endtask
  // a transmit rate written while rx flag is set loads both
  task automatic t_rate();
    rc(BIT_LD_RXR, 1'b1);
    ld(12'(RATE), 12);
    rc(BIT_LD_RXR, 1'b0);
    rc(BIT_LD_TXR, 1'b0);
  endtask
  // character waits for clear to send, line held on
  task automatic t_tx();
    int t;
    wr(BIT_RTS_ON, 1'b1);
    wait_clk(2);
    chk("rts_on", {7'h0, rts_n}, 8'h00);
    ld(12'h05A, 8);
    rc(RD_TX_EMPTY, 1'b0);
    wait_clk(200);
    chk("tx_idle", {7'h0, tx_out}, 8'h01);
    wr(BIT_RTS_ON, 1'b0);
    wait_clk(2);
    chk("rts_hold", {7'h0, rts_n}, 8'h00);
    rc(RD_RTS_ACT, 1'b1);
    cts_en <= 1'b1;
    t = 0;
    while (n_frames != 4'h1 && t < 400) begin
      wait_clk(1);
      t++;
    end
    chk("char", got, 8'h5A);
    wait_clk(20);
    chk("rts_off", {7'h0, rts_n}, 8'h01);
    rc(RD_TX_EMPTY, 1'b1);
    rc(RD_CTS, 1'b1);
    rc(RD_DSC, 1'b1);
    wr(BIT_EN_DSC, 1'b0);
    rc(RD_DSC, 1'b0);
  endtask
  // reload with transmit interrupt left off throughout
  task automatic t_reload();
    wr(BIT_LD_INTV, 1'b1);
    rc(BIT_LD_INTV, 1'b1);
    ld(12'h0A0, 8);
    rc(BIT_LD_INTV, 1'b0);
    rc(RD_TX_EMPTY, 1'b1);
  endtask
  // received character read out, loaded flag cleared
  task automatic t_rx();
    logic [7:0] c;
    logic q;
    logic e;
    rx_char <= 8'hC3;
    rx_strobe <= 1'b1;
    wait_clk(1);
    rx_strobe <= 1'b0;
    rc(RD_RX_LOADED, 1'b1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 1'b0, q, e);
      c[i] = q;
    end
    chk("rx_char", c, 8'hC3);
    wr(BIT_EN_RX, 1'b0);
    rc(RD_RX_LOADED, 1'b0);
  endtask
  // reset command drops a live interrupt, sets flags
  task automatic t_cmd();
    wr(BIT_EN_TX, 1'b1);
    wait_clk(2);
    chk("irq_tx", {7'h0, irq_n}, 8'h00);
    rc(RD_INT, 1'b1);
    wr(BIT_RESET, 1'b1);
    wait_clk(2);
    chk("irq_rst", {7'h0, irq_n}, 8'h01);
    for (int i = 11; i < 15; i++) rc(5'(i), 1'b1);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: reset held 12 cycles, then each scenario
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_char = 8'h00;
    rx_strobe = 1'b0;
    cts_en = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timer();
    t_rate();
    t_tx();
    t_reload();
    t_rx();
    t_cmd();
    wrap_up();
  end
  // Watchdog: the run needs about 1800 cycles
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule // async_comm_host_control_tb
`default_nettype wire
